// File: hdl/fcd_host.v
// Flash command sequencer: takes orders over APB and plays the matching
// write and read cycles on the pins of a parallel NOR flash.
// Assumes one 100 MHz clock, a zero-wait APB master, and a flash whose
// data bus and ready/busy pin arrive asynchronously.
//
// How it works
// - Unlock writes use 555/2AA in word mode, AAA/555 in byte mode.
// - Every command cycle is a write; only array or ID data is read.
// - Identification: two unlocks, 90, then a read at the offset.
// - Program: two unlocks, A0, then location with its value.
// - Shortcut mode entered by unlocks and 20; then A0 plus data.
// - Shortcut mode left by writes 90 then 00 at any address.
// - Chip erase: unlocks, 80, unlocks, 10 at first unlock address.
// - Sector erase: unlocks, 80, unlocks, 30 at sector address.
`include "fcd_map.vh"

module fcd_host (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [19:0] flashAddr,
  output reg [15:0] dqOut,
  output reg dqOe,
  input wire [15:0] dqIn,
  output reg ceN,
  output reg weN,
  output reg oeN,
  output reg byteN,
  input wire readyBusyIn
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WSET = 3'd1;
  localparam [2:0] ST_WLOW = 3'd2;
  localparam [2:0] ST_WHIGH = 3'd3;
  localparam [2:0] ST_RLOW = 3'd4;
  localparam [2:0] ST_REND = 3'd5;
  // Counts are worked out as integers, then cut to the counter width.
  localparam integer WP_FULL = `FCD_CYC(`FCD_TWP_NS);
  localparam integer WPH_FULL = `FCD_CYC(`FCD_TWPH_NS);
  localparam integer RD_FULL = `FCD_CYC(`FCD_TACC_NS) + `FCD_SYNC_CYC;
  localparam [7:0] WP_CYC = WP_FULL[7:0];
  localparam [7:0] WPH_CYC = WPH_FULL[7:0];
  localparam [7:0] RD_CYC = RD_FULL[7:0];

  // ******************************************************************
  // Sequence tables.
  // ******************************************************************

  // Number of write cycles that each order plays before any read.
  function [2:0] nWrites;
    input [3:0] c;
    begin
      case (c)
        `FCD_CMD_READ: nWrites = 3'd0;
        `FCD_CMD_RESET, `FCD_CMD_SUSP, `FCD_CMD_RESUME: nWrites = 3'd1;
        `FCD_CMD_BPROG, `FCD_CMD_BEXIT: nWrites = 3'd2;
        `FCD_CMD_IDENT, `FCD_CMD_BENTER: nWrites = 3'd3;
        `FCD_CMD_PROG: nWrites = 3'd4;
        default: nWrites = 3'd6;
      endcase
    end
  endfunction

  // Returns {address, data} of write cycle idx of order c.
  function [35:0] stepWord;
    input [3:0] c;
    input [2:0] idx;
    input byteM;
    input [19:0] a;
    input [15:0] d;
    reg [19:0] u1;
    reg [19:0] u2;
    reg [7:0] code;
    begin
      u1 = byteM ? `FCD_UNL1_BYTE : `FCD_UNL1_WORD;
      u2 = byteM ? `FCD_UNL2_BYTE : `FCD_UNL2_WORD;
      case (c)
        `FCD_CMD_IDENT: code = `FCD_D_IDENT;
        `FCD_CMD_PROG: code = `FCD_D_PROG;
        `FCD_CMD_BENTER: code = `FCD_D_BYPASS;
        default: code = `FCD_D_ERSETUP;
      endcase
      // Command bytes go out with a zero upper byte; those outside unlock sequences go to address 0.
      case (c)
        `FCD_CMD_RESET: stepWord = {20'h00000, 8'h00, `FCD_D_RESET};
        `FCD_CMD_SUSP: stepWord = {20'h00000, 8'h00, `FCD_D_SUSP};
        `FCD_CMD_RESUME: stepWord = {20'h00000, 8'h00, `FCD_D_RESUME};
        `FCD_CMD_BPROG: stepWord = (idx == 3'd0) ?
          {20'h00000, 8'h00, `FCD_D_PROG} : {a, d};
        `FCD_CMD_BEXIT: stepWord = (idx == 3'd0) ?
          {20'h00000, 8'h00, `FCD_D_BEXIT1} : {20'h00000, 8'h00, `FCD_D_BEXIT2};
        default: begin
          case (idx)
            3'd0, 3'd3: stepWord = {u1, 8'h00, `FCD_D_UNL1};
            3'd1, 3'd4: stepWord = {u2, 8'h00, `FCD_D_UNL2};
            3'd2: stepWord = {u1, 8'h00, code};
            default: begin
              if (c == `FCD_CMD_CHIPER) begin
                stepWord = {u1, 8'h00, `FCD_D_CHIPER};
              end else begin
                stepWord = {a, 8'h00, `FCD_D_SECTER};
              end
            end
          endcase
          if (c == `FCD_CMD_PROG && idx == 3'd3) begin
            stepWord = {a, d};
          end
        end
      endcase
    end
  endfunction

  // ******************************************************************
  // State.
  // ******************************************************************
  reg [3:0] cmd_r;
  reg [19:0] addr_r;
  reg [15:0] wdata_r;
  reg [15:0] rdata_r;
  reg byteMode_r;
  reg bypass_r;
  reg busy_r;
  reg err_r;
  reg done_r;
  reg [2:0] state_r;
  reg [2:0] idx_r;
  reg [7:0] cnt_r;
  reg [15:0] dqMeta_r;
  reg [15:0] dqSync_r;
  reg rbMeta_r;
  reg rbSync_r;
  wire apbWr;
  wire apbRd;
  wire mapped;
  wire ctrlWr;
  wire cmdOk;
  wire [35:0] step;

  // Zero-wait slave; unmapped offsets answer with an error.
  assign pready = 1'b1;
  assign mapped = (paddr == `FCD_OFS_CTRL) || (paddr == `FCD_OFS_ADDR) ||
    (paddr == `FCD_OFS_WDATA) || (paddr == `FCD_OFS_STATUS) ||
    (paddr == `FCD_OFS_RDATA) || (paddr == `FCD_OFS_CFG);
  assign pslverr = psel & penable & ~mapped;
  assign apbWr = psel & penable & pwrite & mapped;
  assign apbRd = psel & ~penable & ~pwrite;
  assign ctrlWr = apbWr && (paddr == `FCD_OFS_CTRL);
  // Shortcut mode accepts only its own program and exit plus plain reads;
  // anything else would break the flash out of it, so it is refused.
  assign cmdOk = (pwdata[3:0] <= `FCD_CMD_RESUME) && (bypass_r ?
    (pwdata[3:0] == `FCD_CMD_BPROG || pwdata[3:0] == `FCD_CMD_BEXIT ||
     pwdata[3:0] == `FCD_CMD_READ) :
    (pwdata[3:0] != `FCD_CMD_BPROG && pwdata[3:0] != `FCD_CMD_BEXIT));
  assign step = stepWord(cmd_r, idx_r, byteMode_r, addr_r, wdata_r);

  // Two-flop synchronisers on the flash data bus and ready/busy pin.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dqMeta_r <= 16'h0000;
      dqSync_r <= 16'h0000;
      rbMeta_r <= 1'b1;
      rbSync_r <= 1'b1;
    end else begin
      dqMeta_r <= dqIn;
      dqSync_r <= dqMeta_r;
      rbMeta_r <= readyBusyIn;
      rbSync_r <= rbMeta_r;
    end
  end

  // Read data is registered in the setup phase so it is stable in access.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (apbRd) begin
      case (paddr)
        `FCD_OFS_CTRL: prdata <= {28'h0000000, cmd_r};
        `FCD_OFS_ADDR: prdata <= {12'h000, addr_r};
        `FCD_OFS_WDATA: prdata <= {16'h0000, wdata_r};
        `FCD_OFS_STATUS: prdata <= {27'h0000000, done_r, err_r, bypass_r,
          rbSync_r, busy_r};
        `FCD_OFS_RDATA: prdata <= {16'h0000, rdata_r};
        `FCD_OFS_CFG: prdata <= {31'h00000000, byteMode_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ******************************************************************
  // Register writes and the pin sequencer.
  // ******************************************************************

  // Each write cycle: setup with select low, strobe low, strobe high.
  // The address is set a cycle ahead of the falling strobe, and data is
  // held through the rising strobe, so both flash latch points are met.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= `FCD_CMD_READ;
      addr_r <= 20'h00000;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      byteMode_r <= `FCD_RST_CFG;
      bypass_r <= 1'b0;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      state_r <= ST_IDLE;
      idx_r <= 3'd0;
      cnt_r <= 8'h00;
      flashAddr <= 20'h00000;
      dqOut <= 16'h0000;
      dqOe <= 1'b0;
      ceN <= 1'b1;
      weN <= 1'b1;
      oeN <= 1'b1;
      byteN <= 1'b1;
    end else begin
      byteN <= ~byteMode_r;
      if (apbWr && !busy_r) begin
        if (paddr == `FCD_OFS_ADDR) addr_r <= pwdata[19:0];
        if (paddr == `FCD_OFS_WDATA) wdata_r <= pwdata[15:0];
        if (paddr == `FCD_OFS_CFG) byteMode_r <= pwdata[`FCD_CFG_BYTE_BIT];
      end
      if (ctrlWr) begin
        if (busy_r || !cmdOk) begin
          err_r <= 1'b1;
        end else begin
          cmd_r <= pwdata[3:0];
          busy_r <= 1'b1;
          err_r <= 1'b0;
          done_r <= 1'b0;
          idx_r <= 3'd0;
          state_r <= (nWrites(pwdata[3:0]) == 3'd0) ? ST_RLOW : ST_WSET;
          cnt_r <= 8'h00;
        end
      end
      case (state_r)
        ST_IDLE: begin
          ceN <= 1'b1;
          oeN <= 1'b1;
          weN <= 1'b1;
          dqOe <= 1'b0;
        end
        ST_WSET: begin
          flashAddr <= step[35:16];
          dqOut <= step[15:0];
          dqOe <= 1'b1;
          ceN <= 1'b0;
          cnt_r <= 8'h00;
          state_r <= ST_WLOW;
        end
        ST_WLOW: begin
          weN <= 1'b0;
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == WP_CYC) begin
            weN <= 1'b1;
            cnt_r <= 8'h00;
            state_r <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          ceN <= 1'b1;
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == WPH_CYC) begin
            dqOe <= 1'b0;
            cnt_r <= 8'h00;
            idx_r <= idx_r + 3'd1;
            if (idx_r + 3'd1 != nWrites(cmd_r)) begin
              state_r <= ST_WSET;
            end else if (cmd_r == `FCD_CMD_IDENT) begin
              state_r <= ST_RLOW;
            end else begin
              state_r <= ST_REND;
            end
          end
        end
        ST_RLOW: begin
          // Access time plus synchroniser delay before sampling data.
          flashAddr <= addr_r;
          dqOe <= 1'b0;
          ceN <= 1'b0;
          oeN <= 1'b0;
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == RD_CYC) begin
            rdata_r <= dqSync_r;
            oeN <= 1'b1;
            ceN <= 1'b1;
            state_r <= ST_REND;
          end
        end
        ST_REND: begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          if (cmd_r == `FCD_CMD_BENTER) bypass_r <= 1'b1;
          if (cmd_r == `FCD_CMD_BEXIT) bypass_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // fcd_host

// File: shared/fcd_map.vh
// Constants of the flash command sequencer: register map, command codes
// and bus timing. Assumes a 100 MHz clock and a flash on an async bus.
`ifndef FCD_MAP_VH
`define FCD_MAP_VH

// ********************************************************************
// Register byte offsets on the APB side.
// ********************************************************************
`define FCD_OFS_CTRL 8'h00
`define FCD_OFS_ADDR 8'h04
`define FCD_OFS_WDATA 8'h08
`define FCD_OFS_STATUS 8'h0C
`define FCD_OFS_RDATA 8'h10
`define FCD_OFS_CFG 8'h14

// Field positions and reset values.
`define FCD_CFG_BYTE_BIT 0
`define FCD_ST_BUSY_BIT 0
`define FCD_ST_RDY_BIT 1
`define FCD_ST_BYP_BIT 2
`define FCD_ST_ERR_BIT 3
`define FCD_ST_DONE_BIT 4
`define FCD_RST_CFG 1'b0

// ********************************************************************
// Orders that software writes into CTRL[3:0].
// ********************************************************************
`define FCD_CMD_READ 4'h0
`define FCD_CMD_RESET 4'h1
`define FCD_CMD_IDENT 4'h2
`define FCD_CMD_PROG 4'h3
`define FCD_CMD_BENTER 4'h4
`define FCD_CMD_BPROG 4'h5
`define FCD_CMD_BEXIT 4'h6
`define FCD_CMD_CHIPER 4'h7
`define FCD_CMD_SECTER 4'h8
`define FCD_CMD_SUSP 4'h9
`define FCD_CMD_RESUME 4'hA

// Unlock addresses for word and byte width, and command data bytes.
`define FCD_UNL1_WORD 20'h00555
`define FCD_UNL2_WORD 20'h002AA
`define FCD_UNL1_BYTE 20'h00AAA
`define FCD_UNL2_BYTE 20'h00555
`define FCD_D_UNL1 8'hAA
`define FCD_D_UNL2 8'h55
`define FCD_D_RESET 8'hF0
`define FCD_D_IDENT 8'h90
`define FCD_D_PROG 8'hA0
`define FCD_D_BYPASS 8'h20
`define FCD_D_ERSETUP 8'h80
`define FCD_D_CHIPER 8'h10
`define FCD_D_SECTER 8'h30
`define FCD_D_SUSP 8'hB0
`define FCD_D_RESUME 8'h30
`define FCD_D_BEXIT1 8'h90
`define FCD_D_BEXIT2 8'h00

// ********************************************************************
// Bus timing, in ns, and the derived clock counts (rounded up).
// ********************************************************************
`define FCD_CLK_MHZ 100
`define FCD_TWP_NS 40
`define FCD_TWPH_NS 30
`define FCD_TACC_NS 80
`define FCD_SYNC_CYC 2
`define FCD_CYC(ns) (((ns) * `FCD_CLK_MHZ + 999) / 1000)

`endif

// File: test/fcd_flash_model.sv
// Behavioural flash that answers the sequencer's strobes.
// Assumes ceN falls before weN; it uses no clock of its own.
module fcd_flash_model #(
  parameter logic [15:0] MAKER = 16'h00C3, // Arbitrary value.
  parameter logic [15:0] DEVID = 16'h4E17, // Arbitrary value.
  parameter int PROG_NS = 1500,
  parameter int ERASE_NS = 4000
) (
  input logic [19:0] flashAddr,
  input logic [15:0] dqOut,
  input logic ceN,
  input logic weN,
  input logic oeN,
  input logic byteN,
  output logic [15:0] dqIn,
  output logic readyBusyIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [19:0] adr_r;
  logic [15:0] rd_r = 0;
  logic [15:0] pd_r = 0;
  logic [7:0] lastOp = 0;
  int step_r = 0;
  int left_r = 0;
  logic ident_r = 0, byp_r = 0, sect_r = 0, susp_r = 0, tog_r = 0;
  wire [10:0] u1 = byteN ? 11'h555 : 11'hAAA;
  wire [10:0] u2 = byteN ? 11'h2AA : 11'h555;
  wire busy = left_r > 0 && !susp_r;
  // A released bus shows the inverse, so a late sample cannot pass.
  assign dqIn = (!oeN && !ceN) ? rd_r : ~rd_r;
  assign readyBusyIn = !busy;
  always #10 if (busy) left_r = left_r - 10;
  task automatic start(input int ns, input logic s, input logic [7:0] op);
    left_r = ns;
    sect_r = s;
    lastOp = op;
    if (op != 8'hA0) pd_r = 16'hFFFF;
  endtask
  // The address latches when the write strobe falls last.
  always @(negedge weN) adr_r = flashAddr;
  // Each write moves the sequence on; a stray one drops it.
  always @(posedge weN) begin
    logic [7:0] d;
    logic [10:0] a;
    d = dqOut[7:0];
    a = adr_r[10:0];
    if (busy) begin
      if (d == 8'hB0 && sect_r) begin
        susp_r = 1;
        lastOp = d;
      end
    end else case (step_r)
      0: if (d == 8'hF0) ident_r = 0;
        else if (susp_r && d == 8'h30) begin
          susp_r = 0;
          lastOp = d;
        end else if (byp_r) step_r = d == 8'hA0 ? 7 : d == 8'h90 ? 8 : 0;
        else if (a == u1 && d == 8'hAA) step_r = 1;
      1, 4: step_r = (a == u2 && d == 8'h55) ? step_r + 1 : 0;
      2: begin
        step_r = d == 8'hA0 ? 7 : d == 8'h80 ? 3 : 0;
        if (d == 8'h90) ident_r = 1;
        if (d == 8'h20) byp_r = 1;
        if (d inside {8'h90, 8'h20}) lastOp = d;
      end
      3: step_r = (a == u1 && d == 8'hAA) ? 4 : 0;
      5: begin
        step_r = 0;
        if (d == 8'h10 && a == u1) begin
          mem.delete();
          start(ERASE_NS, 0, d);
        end
        if (d == 8'h30) begin
          foreach (mem[k]) if (k[18:12] == adr_r[18:12]) mem[k] = 16'hFFFF;
          start(ERASE_NS, 1, d);
        end
      end
      7: begin
        step_r = 0;
        mem[adr_r] = dqOut;
        pd_r = dqOut;
        start(PROG_NS, 0, 8'hA0);
      end
      default: begin
        step_r = 0;
        if (d inside {8'h00, 8'hF0}) byp_r = 0;
        if (d inside {8'h00, 8'hF0}) lastOp = d;
      end
    endcase
  end
  // Status replaces array data while an operation runs.
  always @(negedge oeN) begin
    logic [1:0] ix;
    ix = byteN ? flashAddr[1:0] : flashAddr[2:1];
    tog_r = busy ? !tog_r : tog_r;
    if (busy) rd_r = {8'h00, ~pd_r[7], tog_r, 6'h00};
    else if (ident_r) rd_r = ix == 0 ? MAKER : ix == 1 ? DEVID : 0;
    else rd_r = mem.exists(flashAddr) ? mem[flashAddr] : 16'hFFFF;
  end
endmodule // fcd_flash_model

// File: test/fcd_props.sv
// Checker of the flash pin side of the command sequencer.
// Assumes the zero-wait step timing of the sequencer, bound below.
module fcd_props (
  input logic clk,
  input logic rst_n,
  input logic [19:0] flashAddr,
  input logic [15:0] dqOut,
  input logic dqOe,
  input logic ceN,
  input logic weN,
  input logic oeN,
  input logic byteN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // One write step, seen at the edge where the write strobe falls.
  sequence s_wr(logic [19:0] a, logic [15:0] d);
    $fell(weN) && flashAddr == a && dqOut == d;
  endsequence
  // Each step lasts ten clocks, so the next strobe falls ten edges later.
  property p_unl_word;
    byteN ##0 s_wr(20'h00555, 16'h00AA) |-> ##10 s_wr(20'h002AA, 16'h0055);
  endproperty
  property p_unl_byte;
    !byteN ##0 s_wr(20'h00AAA, 16'h00AA) |-> ##10 s_wr(20'h00555, 16'h0055);
  endproperty
  property p_cmd_upper;
    byteN ##0 s_wr(20'h002AA, 16'h0055) |->
      ##10 $fell(weN) && dqOut[15:8] == 8'h00;
  endproperty
  property p_we_pulse;
    $fell(weN) |-> (!weN && !ceN && oeN && dqOe)[*4] ##1 weN;
  endproperty
  property p_addr_hold;
    !weN |-> $stable(flashAddr) && $stable(dqOut);
  endproperty
  property p_data_hold;
    $rose(weN) |-> $stable(dqOut) && dqOe;
  endproperty
  property p_rd_len;
    $fell(oeN) |-> (!oeN && !ceN && !dqOe && weN)[*8] ##[1:6] oeN;
  endproperty
  property p_byte_stable;
    !ceN |-> $stable(byteN);
  endproperty
  a_unl_word: assert property (p_unl_word)
    else $error("word unlock pair wrong");
  a_unl_byte: assert property (p_unl_byte)
    else $error("byte unlock pair wrong");
  a_cmd_upper: assert property (p_cmd_upper)
    else $error("command upper byte not zero");
  a_we_pulse: assert property (p_we_pulse)
    else $error("write pulse shape wrong");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved in write pulse");
  a_data_hold: assert property (p_data_hold)
    else $error("data moved at strobe rise");
  a_rd_len: assert property (p_rd_len)
    else $error("read cycle shape wrong");
  a_byte_stable: assert property (p_byte_stable)
    else $error("width select moved in a cycle");
endmodule // fcd_props

bind fcd_host fcd_props u_fcd_props (.clk(clk), .rst_n(rst_n),
  .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN),
  .weN(weN), .oeN(oeN), .byteN(byteN));

// File: test/tb_top.sv
// Self-checking bench: APB orders to the sequencer, flash model behind.
// Assumes the sequencer header is on the include path.
`include "fcd_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MK = 16'h00C3; // Arbitrary value.
  localparam logic [15:0] DV = 16'h4E17; // Arbitrary value.
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, t, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, q, st;
  logic [19:0] a, b, e;
  logic [15:0] d;
  integer seed = 32'hd637dd62;
  int failures = 0, compares = 0, cyc = 0;
  logic [19:0] ida [6] = '{0, 1, 20'h7F002, 0, 2, 20'h7F004};
  logic [15:0] idv [6] = '{MK, DV, 0, MK, DV, 0};
  wire [31:0] prdata;
  wire [19:0] flashAddr;
  wire [15:0] dqOut, dqIn;
  wire pready, pslverr, dqOe, ceN, weN, oeN, byteN, readyBusyIn;
  fcd_host u_fcd_host (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn),
    .ceN(ceN), .weN(weN), .oeN(oeN), .byteN(byteN),
    .readyBusyIn(readyBusyIn));
  fcd_flash_model #(.MAKER(MK), .DEVID(DV)) u_fcd_flash_model (
    .flashAddr(flashAddr), .dqOut(dqOut), .ceN(ceN), .weN(weN),
    .oeN(oeN), .byteN(byteN), .dqIn(dqIn), .readyBusyIn(readyBusyIn));
  always #5 clk = ~clk;
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Setup then access; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // Issue an order and poll until the sequencer is idle again.
  task automatic go(input logic [3:0] c, input logic [19:0] ad, input logic [15:0] wd);
    apb(1, `FCD_OFS_ADDR, {12'h000, ad});
    apb(1, `FCD_OFS_WDATA, {16'h0000, wd});
    apb(1, `FCD_OFS_CTRL, {28'h0000000, c});
    do apb(0, `FCD_OFS_STATUS, 0); while (q[0] !== 1'b0);
    st = q;
  endtask
  task automatic rdChk(input logic [19:0] ad, input logic [15:0] m, input logic [15:0] x);
    go(`FCD_CMD_READ, ad, 0);
    apb(0, `FCD_OFS_RDATA, 0);
    chk(q[15:0] & m, x);
  endtask
  task automatic waitRdy();
    repeat (200) begin
      apb(0, `FCD_OFS_STATUS, 0);
      if (q[1] === 1'b1) break;
    end
    chk(q[1], 1);
  endtask
  // ********
  // Main sequence.
  // ********
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      a = {1'b0, 7'($random(seed)) | 7'h10, 12'($random(seed))};
      d = 16'($random(seed));
      go(`FCD_CMD_PROG, a, d);
      chk(u_fcd_flash_model.lastOp, 8'hA0);
      rdChk(a, 16'h0080, {~d[7], 7'h00});
      t = q[6];
      rdChk(a, 16'h0040, {~t, 6'h00});
      waitRdy();
      rdChk(a, 16'hFFFF, d);
    end
    b = a ^ 20'h01000;
    e = a ^ 20'h02000;
    go(`FCD_CMD_PROG, b, ~d);
    waitRdy();
    $display("done: program");
    for (int i = 0; i < 6; i++) begin
      apb(1, `FCD_OFS_CFG, i / 3);
      go(`FCD_CMD_IDENT, ida[i], 0);
      apb(0, `FCD_OFS_RDATA, 0);
      chk(q[15:0], idv[i]);
    end
    go(`FCD_CMD_RESET, 0, 0);
    apb(1, `FCD_OFS_CFG, 0);
    rdChk(a, 16'hFFFF, d);
    $display("done: identification");
    go(`FCD_CMD_BENTER, 0, 0);
    chk(st[2], 1);
    go(`FCD_CMD_PROG, a, 0);
    chk(st[3], 1);
    go(`FCD_CMD_BPROG, e, d);
    waitRdy();
    go(`FCD_CMD_BEXIT, 0, 0);
    chk(st[2], 0);
    chk(u_fcd_flash_model.lastOp, 0);
    rdChk(e, 16'hFFFF, d);
    $display("done: shortcut");
    go(`FCD_CMD_SECTER, a, 0);
    go(`FCD_CMD_SUSP, 0, 0);
    chk(u_fcd_flash_model.lastOp, 8'hB0);
    waitRdy();
    rdChk(b, 16'hFFFF, ~d);
    go(`FCD_CMD_RESUME, 0, 0);
    chk(u_fcd_flash_model.lastOp, 8'h30);
    waitRdy();
    rdChk(a, 16'hFFFF, 16'hFFFF);
    rdChk(b, 16'hFFFF, ~d);
    go(`FCD_CMD_CHIPER, 0, 0);
    go(`FCD_CMD_SUSP, 0, 0);
    chk(u_fcd_flash_model.lastOp, 8'h10);
    waitRdy();
    rdChk(b, 16'hFFFF, 16'hFFFF);
    $display("done: erase");
    apb(0, 8'h3C, 0);
    chk(err, 1);
    $display("done: unmapped");
    complete_run();
  end
endmodule // tb_top
